// ---- design/rtc_ramp_tail.v ----
// ramp segment 1 tail control, post-ramp calibration, scaled wait and calibration readback registers
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`include "rtc_ramp_tail_regs.vh"

module rtc_ramp_tail (
	// clock and reset
	input  wire                    clk_sys,
	input  wire                    resetn,
	// register port
	input  wire [`RTC_ADDR_W-1:0]  reg_addr,
	input  wire [`RTC_DATA_W-1:0]  reg_wdata,
	input  wire                    reg_write,
	input  wire                    reg_read,
	output reg  [`RTC_DATA_W-1:0]  reg_rdata,
	// ramp engine side, same clock
	input  wire                    seg1_active,
	input  wire                    seg1_length_done,
	input  wire                    trigger_a,
	input  wire                    trigger_b,
	input  wire                    ramp_done,
	input  wire                    ramp_manual,
	output reg                     seg1_end,
	output reg                     next_is_seg1,
	// oscillator calibration side
	output reg                     cal_start,
	input  wire                    cal_busy,
	input  wire                    cal_result_valid,
	input  wire [2:0]              cal_core,
	input  wire [7:0]              cal_capcode,
	input  wire [8:0]              cal_amplitude,
	output reg                     cal_wait_done,
	// tuning-voltage lock detector, from a pin
	input  wire [1:0]              tuning_lock_pin,
	// interrupt
	output wire                    irq
);

////////////////////////////////////////////////////////////////////////////////
	// reset release
	reg        rst_meta;
	reg        rst_sync;
	wire       rstn = rst_sync;

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// functions
	function [`RTC_WAIT_W-1:0] scaled_wait;
		input [9:0] count;
		input [2:0] expo;
		begin
			scaled_wait = {7'h00, count} << expo;
		end
	endfunction

	function hit;
		input [`RTC_ADDR_W-1:0] addr;
		input [`RTC_ADDR_W-1:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

////////////////////////////////////////////////////////////////////////////////
	// control registers
	reg [1:0]  ramp1_advance_source;
	reg        ramp1_successor;
	reg [9:0]  ramp_wait_count;
	reg        post_ramp_calibrate;
	reg [2:0]  ramp_wait_exponent;
	reg [`RTC_IRQ_W-1:0] irq_mask;

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ramp1_advance_source <= `RTC_RST_SOURCE;
			ramp1_successor      <= `RTC_RST_SUCCESSOR;
			ramp_wait_count      <= `RTC_RST_WAIT_COUNT;
			post_ramp_calibrate  <= `RTC_RST_CAL_EN;
			ramp_wait_exponent   <= `RTC_RST_EXPONENT;
			irq_mask             <= {`RTC_IRQ_W{1'b0}};
		end else if (reg_write) begin
			if (hit(reg_addr, `RTC_OFS_SUCC_CTRL)) begin
				ramp_wait_count      <= reg_wdata[15:6];
				ramp1_successor      <= reg_wdata[4];
				ramp1_advance_source <= reg_wdata[1:0];
			end
			if (hit(reg_addr, `RTC_OFS_SCALE_CTRL)) begin
				post_ramp_calibrate <= reg_wdata[4];
				ramp_wait_exponent  <= reg_wdata[2:0];
			end
			if (hit(reg_addr, `RTC_OFS_IRQ_MASK))
				irq_mask <= reg_wdata[`RTC_IRQ_W-1:0];
			// readback offsets have no write path at all
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// segment 1 end and successor
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			seg1_end     <= 1'b0;
			next_is_seg1 <= 1'b0;
		end else begin
			case (ramp1_advance_source)
				`RTC_SRC_TIMEOUT: seg1_end <= seg1_active & seg1_length_done;
				`RTC_SRC_TRIG_A:  seg1_end <= seg1_active & trigger_a;
				`RTC_SRC_TRIG_B:  seg1_end <= seg1_active & trigger_b;
				default:          seg1_end <= 1'b0;
			endcase
			next_is_seg1 <= ramp1_successor;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// post-ramp calibration and scaled wait
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_HOLD = 2'h2;

	reg [1:0]              state;
	reg [`RTC_WAIT_W-1:0]  wait_left;
	wire [`RTC_WAIT_W-1:0] wait_total = scaled_wait(ramp_wait_count, ramp_wait_exponent);

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state         <= ST_IDLE;
			wait_left     <= {`RTC_WAIT_W{1'b0}};
			cal_start     <= 1'b0;
			cal_wait_done <= 1'b0;
		end else begin
			cal_start     <= 1'b0;
			cal_wait_done <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (ramp_done && post_ramp_calibrate) begin
						cal_start <= 1'b1;
						wait_left <= wait_total;
						state     <= ramp_manual ? ST_HOLD : ST_WAIT;
					end
				end
				ST_WAIT: begin
					// lasts the longer of scaled count and calibration
					if (wait_left != {`RTC_WAIT_W{1'b0}})
						wait_left <= wait_left - 1'b1;
					if (wait_left <= 1 && !cal_busy && !cal_start) begin
						cal_wait_done <= 1'b1;
						state         <= ST_IDLE;
					end
				end
				ST_HOLD: begin
					if (!cal_busy && !cal_start) begin
						cal_wait_done <= 1'b1;
						state         <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// calibration results and lock synchroniser
	reg [2:0] chosen_oscillator_readback;
	reg [7:0] chosen_capcode_readback;
	reg [8:0] chosen_amplitude_readback;
	reg [1:0] lock_s1;
	reg [1:0] lock_s2;
	reg [1:0] lock_s3;
	reg [1:0] tuning_lock_readback;

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			chosen_oscillator_readback <= `RTC_RST_CORE;
			chosen_capcode_readback    <= `RTC_RST_CAPCODE;
			chosen_amplitude_readback  <= `RTC_RST_AMPLITUDE;
			lock_s1                    <= `RTC_RST_LOCK;
			lock_s2                    <= `RTC_RST_LOCK;
			lock_s3                    <= `RTC_RST_LOCK;
			tuning_lock_readback       <= `RTC_RST_LOCK;
		end else begin
			if (cal_result_valid) begin
				chosen_oscillator_readback <= cal_core;
				chosen_capcode_readback    <= cal_capcode;
				chosen_amplitude_readback  <= cal_amplitude;
			end
			lock_s1 <= tuning_lock_pin;
			lock_s2 <= lock_s1;
			lock_s3 <= lock_s2;
			if (lock_s2 == lock_s3)
				tuning_lock_readback <= lock_s3;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// interrupt status, cleared by reading it; a new event wins over the clear
	reg  [`RTC_IRQ_W-1:0] irq_status;
	reg  [1:0]            lock_prev;
	wire [`RTC_IRQ_W-1:0] irq_event;
	wire                  status_rd = reg_read & hit(reg_addr, `RTC_OFS_IRQ_STATUS);

	assign irq_event[`RTC_IRQ_SEG_DONE]  = seg1_end;
	assign irq_event[`RTC_IRQ_CAL_START] = cal_start;
	assign irq_event[`RTC_IRQ_WAIT_DONE] = cal_wait_done;
	assign irq_event[`RTC_IRQ_LOCK_CHG]  = (lock_prev != tuning_lock_readback);

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_status <= {`RTC_IRQ_W{1'b0}};
			lock_prev  <= `RTC_RST_LOCK;
		end else begin
			lock_prev  <= tuning_lock_readback;
			irq_status <= (status_rd ? {`RTC_IRQ_W{1'b0}} : irq_status) | irq_event;
		end
	end

	assign irq = |(irq_status & irq_mask);

////////////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe
	reg [`RTC_DATA_W-1:0] next_rdata;

	always @* begin
		next_rdata = {`RTC_DATA_W{1'b0}};
		case (reg_addr)
			`RTC_OFS_SUCC_CTRL:  next_rdata = {ramp_wait_count, 1'b0, ramp1_successor, 2'h0, ramp1_advance_source};
			`RTC_OFS_SCALE_CTRL: next_rdata = {11'h000, post_ramp_calibrate, 1'b0, ramp_wait_exponent};
			`RTC_OFS_LOCK_CORE:  next_rdata = {5'h00, tuning_lock_readback, 1'b0,
				chosen_oscillator_readback, 5'h00};
			`RTC_OFS_CAPCODE:    next_rdata = {8'h00, chosen_capcode_readback};
			`RTC_OFS_AMPLITUDE:  next_rdata = {7'h00, chosen_amplitude_readback};
			`RTC_OFS_IRQ_STATUS: next_rdata = {12'h000, irq_status};
			`RTC_OFS_IRQ_MASK:   next_rdata = {12'h000, irq_mask};
			default:             next_rdata = {`RTC_DATA_W{1'b0}};
		endcase
	end

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			reg_rdata <= {`RTC_DATA_W{1'b0}};
		else if (reg_read)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= {`RTC_DATA_W{1'b0}};
	end

endmodule // rtc_ramp_tail

// ---- design/rtc_ramp_tail_regs.vh ----
// register offsets, field positions, reset values and the wait counter width for the ramp tail block
`ifndef RTC_RAMP_TAIL_REGS_VH
`define RTC_RAMP_TAIL_REGS_VH

`define RTC_ADDR_W          7
`define RTC_DATA_W          16
`define RTC_OFS_SUCC_CTRL   7'h69
`define RTC_OFS_SCALE_CTRL  7'h6a
`define RTC_OFS_LOCK_CORE   7'h6e
`define RTC_OFS_CAPCODE     7'h6f
`define RTC_OFS_AMPLITUDE   7'h70
`define RTC_OFS_IRQ_STATUS  7'h78
`define RTC_OFS_IRQ_MASK    7'h79

`define RTC_SRC_TIMEOUT     2'h0
`define RTC_SRC_TRIG_A      2'h1
`define RTC_SRC_TRIG_B      2'h2
`define RTC_SRC_RSVD        2'h3

`define RTC_RST_SOURCE      2'h0
`define RTC_RST_SUCCESSOR   1'h0
`define RTC_RST_WAIT_COUNT  10'h000
`define RTC_RST_CAL_EN      1'h0
`define RTC_RST_EXPONENT    3'h7
`define RTC_RST_CAPCODE     8'hb7
`define RTC_RST_AMPLITUDE   9'haa
`define RTC_RST_CORE        3'h0
`define RTC_RST_LOCK        2'h0

`define RTC_IRQ_W           4
`define RTC_IRQ_SEG_DONE    0
`define RTC_IRQ_CAL_START   1
`define RTC_IRQ_WAIT_DONE   2
`define RTC_IRQ_LOCK_CHG    3

`define RTC_WAIT_W          17

`endif

// ---- sim/rtc_ramp_tail_props.sv ----
// assertion checker for the ramp tail block
`timescale 1ns/100ps
module rtc_ramp_tail_props (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        resetn,
	// register port
	input wire logic        reg_read,
	input wire logic [15:0] reg_rdata,
	// ramp and calibration
	input wire logic        seg1_active,
	input wire logic        seg1_length_done,
	input wire logic        trigger_a,
	input wire logic        trigger_b,
	input wire logic        ramp_done,
	input wire logic        cal_busy,
	input wire logic        seg1_end,
	input wire logic        cal_start,
	input wire logic        cal_wait_done
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence s_start; cal_start; endsequence
	chk_rdata_slot: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000) else $error("rdata leak");
	chk_seg_active: assert property (seg1_end |-> $past(seg1_active)) else $error("end outside seg1");
	chk_seg_cause: assert property (seg1_end |-> $past(seg1_length_done || trigger_a || trigger_b)) else $error("end no cause");
	chk_seg_single: assert property (seg1_end && !(seg1_active && (seg1_length_done || trigger_a || trigger_b))
		|=> !seg1_end) else $error("end stuck");
	chk_cal_cause: assert property (s_start |-> $past(ramp_done)) else $error("start no ramp");
	chk_cal_pulse: assert property (s_start |=> !cal_start) else $error("start stuck");
	chk_wait_pulse: assert property (cal_wait_done |=> !cal_wait_done) else $error("done stuck");
	chk_wait_idle: assert property (cal_wait_done |-> !$past(cal_busy)) else $error("done while busy");
endmodule // rtc_ramp_tail_props
bind rtc_ramp_tail rtc_ramp_tail_props u_props (.clk_sys(clk_sys), .resetn(resetn), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .seg1_active(seg1_active), .seg1_length_done(seg1_length_done), .trigger_a(trigger_a),
	.trigger_b(trigger_b), .ramp_done(ramp_done), .cal_busy(cal_busy), .seg1_end(seg1_end), .cal_start(cal_start),
	.cal_wait_done(cal_wait_done));

// ---- sim/test_ramp_tail_and_cal_readback.sv ----
// self-checking bench for the ramp tail block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_ramp_tail_and_cal_readback;
	logic        clk_sys, resetn, reg_write, reg_read, seg1_active, seg1_length_done, trigger_a, trigger_b;
	logic        ramp_done, ramp_manual, cal_busy, cal_result_valid, seg1_end, next_is_seg1, cal_start;
	logic        cal_wait_done, irq;
	logic [6:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [2:0]  cal_core;
	logic [7:0]  cal_capcode;
	logic [8:0]  cal_amplitude;
	logic [1:0]  tuning_lock_pin;
	int          error_cnt = 0, n_tests = 0, n;
	rtc_ramp_tail dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .seg1_active(seg1_active),
		.seg1_length_done(seg1_length_done), .trigger_a(trigger_a), .trigger_b(trigger_b), .ramp_done(ramp_done),
		.ramp_manual(ramp_manual), .seg1_end(seg1_end), .next_is_seg1(next_is_seg1), .cal_start(cal_start),
		.cal_busy(cal_busy), .cal_result_valid(cal_result_valid), .cal_core(cal_core), .cal_capcode(cal_capcode),
		.cal_amplitude(cal_amplitude), .cal_wait_done(cal_wait_done), .tuning_lock_pin(tuning_lock_pin), .irq(irq));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1;
		`CHK("reg_rdata", e, reg_rdata)
	endtask
	task automatic t_reset;
		rd(7'h69, 16'h0000);
		rd(7'h6a, 16'h0007);
		rd(7'h6e, 16'h0000);
		rd(7'h6f, 16'h00b7);
		rd(7'h70, 16'h00aa);
		rd(7'h00, 16'h0000);
		$display("reset values done");
	endtask
	task automatic t_access;
		wr(7'h69, 16'hffff);
		rd(7'h69, 16'hffd3);
		`CHK("next_is_seg1", 1'b1, next_is_seg1)
		wr(7'h6a, 16'hffff);
		rd(7'h6a, 16'h0017);
		for (int a = 'h6e; a <= 'h70; a++) wr(a[6:0], 16'hffff);
		rd(7'h6e, 16'h0000);
		rd(7'h6f, 16'h00b7);
		rd(7'h70, 16'h00aa);
		wr(7'h69, 16'h0000);
		rd(7'h69, 16'h0000);
		`CHK("next_is_seg1", 1'b0, next_is_seg1)
		$display("access kinds done");
	endtask
	task automatic t_seg;
		wr(7'h79, 16'h0001);
		seg1_active <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			wr(7'h69, 16'(s));
			for (int k = 0; k < 3; k++) begin
				@(posedge clk_sys);
				{trigger_b, trigger_a, seg1_length_done} <= 3'b001 << k;
				@(posedge clk_sys);
				{trigger_b, trigger_a, seg1_length_done} <= 3'b000;
				#1;
				`CHK("seg1_end", s == k, seg1_end)
			end
		end
		seg1_active <= 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK("irq", 1'b1, irq)
		rd(7'h78, 16'h0001);
		`CHK("irq", 1'b0, irq)
		$display("segment end done");
	endtask
	// busy holds the calibration for that many cycles, 0 for none
	task automatic t_cal(input logic [9:0] cnt, input logic [2:0] ex, input logic en, input int busy);
		wr(7'h69, {cnt, 6'h00});
		wr(7'h6a, {11'h000, en, 1'b0, ex});
		@(posedge clk_sys);
		ramp_done <= 1'b1;
		cal_busy <= (busy > 0);
		@(posedge clk_sys);
		ramp_done <= 1'b0;
		#1;
		`CHK("cal_start", en, cal_start)
		n = 0;
		while (en && !cal_wait_done && n < 2000) begin
			@(posedge clk_sys);
			n++;
			if (n == busy) cal_busy <= 1'b0;
			#1;
		end
		if (!en) `CHK("cal_wait_done", 1'b0, cal_wait_done)
		else if (busy == 0) `CHK("wait_cycles", int'(cnt) << ex, n)
		else `CHK("wait_slow", 1'b1, n >= busy && n <= busy + 2)
		$display("calibration wait done");
	endtask
	task automatic t_result;
		@(posedge clk_sys);
		{cal_core, cal_capcode, cal_amplitude} <= {3'h5, 8'h3c, 9'h1a5};
		cal_result_valid <= 1'b1;
		tuning_lock_pin <= 2'h2;
		@(posedge clk_sys);
		cal_result_valid <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rd(7'h6e, 16'h04a0);
		rd(7'h6f, 16'h003c);
		rd(7'h70, 16'h01a5);
		`CHK("irq_masked", 1'b0, irq)
		rd(7'h78, 16'h000e);
		$display("readback done");
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{reg_addr, reg_wdata, reg_write, reg_read, seg1_active, seg1_length_done, trigger_a, trigger_b} = '0;
		{ramp_done, ramp_manual, cal_busy, cal_result_valid, cal_core, cal_capcode, cal_amplitude} = '0;
		tuning_lock_pin = 2'h0;
		resetn = 1'b0;
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_reset;
		t_access;
		t_seg;
		t_cal(10'd3, 3'd1, 1'b1, 0);
		t_cal(10'd1, 3'd7, 1'b1, 0);
		t_cal(10'd2, 3'd1, 1'b1, 20);
		t_cal(10'd1, 3'd1, 1'b0, 0);
		ramp_manual <= 1'b1;
		t_cal(10'd50, 3'd1, 1'b1, 20);
		ramp_manual <= 1'b0;
		t_result;
		summarize;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		summarize;
	end
endmodule // test_ramp_tail_and_cal_readback
